// file: stc_pkg.sv
// Package with register map, field positions and timing constants for the supply tracker.
package stc_pkg;
   // Register offsets
   localparam logic [7:0] UV_THRESHOLD_CH1          = 8'h00;
   localparam logic [7:0] OV_THRESHOLD_CH1          = 8'h04;
   localparam logic [7:0] THRESHOLD_RANGE_SELECT    = 8'h08;
   localparam logic [7:0] DEVICE_ROLE_FAULT_ENABLE  = 8'h09;
   localparam logic [7:0] FAULT_TIMEOUT_CONFIG      = 8'h0a;
   localparam logic [7:0] TRACK_SEQ_MODE_A          = 8'h0b;
   localparam logic [7:0] TRACK_SEQ_MODE_B          = 8'h0c;
   localparam logic [7:0] OVERCURRENT_THRESHOLD     = 8'h0d;
   localparam logic [7:0] OVERCURRENT_MASK_FILTER   = 8'h0e;
   localparam logic [7:0] POWERUP_DELAY_CONFIG      = 8'h0f;
   localparam logic [7:0] POWER_GOOD_THRESHOLD      = 8'h10;
   localparam logic [7:0] RESET_MASK_TIMEOUT        = 8'h11;
   localparam logic [7:0] SLEW_RATE_CONFIG          = 8'h12;
   localparam logic [7:0] POWERDOWN_PULLDOWN_CONFIG = 8'h13;
   localparam int         NUM_REGS                  = 20;
   localparam logic [4:0] LAST_IDX                  = 5'h13;
   localparam logic [7:0] CFG_RESET                 = 8'h00;
   // Serial command codes
   localparam logic [7:0] CMD_NV_BASE               = 8'h20;
   localparam logic [7:0] CMD_NV_LAST               = 8'h33;
   localparam logic [7:0] CMD_BLOCK_WRITE           = 8'h83;
   localparam logic [7:0] CMD_BLOCK_WR_PREP         = 8'hc0;
   localparam logic [7:0] CMD_BLOCK_RD_PREP         = 8'hc1;
   localparam logic [7:0] CMD_REBOOT                = 8'hc4;
   localparam logic [3:0] DEV_ADDR_HI               = 4'ha;
   // Field positions
   localparam int ROLE_HI = 7;
   localparam int ROLE_LO = 6;
   localparam int RETRY_BIT = 5;
   localparam int HOST_PERM_BIT = 1;
   localparam int HOST_EN_BIT = 0;
   localparam int FTO_HI = 7;
   localparam int FTO_LO = 4;
   localparam int OC_FILT_HI = 7;
   localparam int OC_FILT_LO = 6;
   localparam int OC_MASK_HI = 5;
   localparam int OC_MASK_LO = 2;
   localparam int DLY_HI = 7;
   localparam int DLY_LO = 5;
   localparam int RST_MASK_HI = 7;
   localparam int RST_MASK_LO = 4;
   localparam int RST_TO_HI = 3;
   localparam int RST_TO_LO = 1;
   localparam int SLEW_HI = 7;
   localparam int SLEW_LO = 6;
   localparam int PDN_FAST_BIT = 7;
   localparam int PULL_HI = 6;
   localparam int PULL_LO = 3;
   localparam logic [3:0] MODE_TRACK = 4'h0;
   localparam logic [1:0] SLEW_FAULT = 2'h3;
   // Timing
   localparam int CLK_MHZ       = 100;
   localparam int OC_BASE_US    = 12500;
   localparam int RST_MIN_US    = 25;
   localparam int RST_MIN_CYC   = RST_MIN_US * CLK_MHZ;
   localparam int RST_STEP_US   = 12500;
   localparam int FAULT_STEP_US = 10000;
   localparam int RETRY_US      = 100000;
   localparam int SYNC_W        = 16;
endpackage : stc_pkg

// file: stc_config_regs.sv
// Configuration registers, serial slave and supervisory control of the supply tracker.
`timescale 1ns/1ps
`default_nettype none
module stc_config_regs #(
   parameter int unsigned OC_BASE_CYC   = stc_pkg::OC_BASE_US * stc_pkg::CLK_MHZ,
   parameter int unsigned RST_STEP_CYC  = stc_pkg::RST_STEP_US * stc_pkg::CLK_MHZ,
   parameter int unsigned FAULT_STEP_CYC = stc_pkg::FAULT_STEP_US * stc_pkg::CLK_MHZ,
   parameter int unsigned RETRY_CYC     = stc_pkg::RETRY_US * stc_pkg::CLK_MHZ
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        scl,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic [1:0]  addrPin,
   input  wire logic        enablePin,
   input  wire logic [3:0]  ocDetect,
   input  wire logic [3:0]  outGood,
   input  wire logic        rampDone,
   input  wire logic        trackFault,
   output logic             overcurrentAlertOut,
   output logic             faultAlert,
   output logic             resetOutN,
   output logic             powerOn,
   output logic             fastShutdown,
   output logic [3:0]       pulldownEn,
   output logic [1:0]       slewSel,
   output logic [2:0]       seqDelaySel,
   output logic [15:0]      outMode,
   output logic [1:0]       deviceRole,
   output logic [3:0]       rangeSel,
   output logic [31:0]      uvThreshold,
   output logic [31:0]      ovThreshold,
   output logic [7:0]       ocThreshold,
   output logic [7:0]       pgThreshold
);
   import stc_pkg::*;
   typedef enum logic [2:0] {I_IDLE = 3'b000, I_ADDR = 3'b001, I_CMD = 3'b010,
                             I_WDATA = 3'b011, I_RDATA = 3'b100, I_RACK = 3'b101} stc_i2c_t;
   function automatic logic [4:0] satInc(input logic [4:0] idx);
      satInc = (idx == LAST_IDX) ? LAST_IDX : 5'(idx + 5'h01);
   endfunction : satInc
   function automatic logic [31:0] cycOf(input logic [31:0] mult, input logic [31:0] unitCyc);
      cycOf = 32'(mult * unitCyc);
   endfunction : cycOf
   // Mask fields hold OUT1 in their top bit, status inputs carry OUT1 in bit 0
   function automatic logic [3:0] chanOrder(input logic [3:0] f);
      chanOrder = {f[0], f[1], f[2], f[3]};
   endfunction : chanOrder
   // Input synchronisers
   logic [SYNC_W-1:0] syncA_reg;
   logic [SYNC_W-1:0] syncB_reg;
   logic              sclD_reg;
   logic              sdaD_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         syncA_reg <= {2'b11, 14'h0000}; // Bus idles high, status inputs idle low
         syncB_reg <= {2'b11, 14'h0000};
         sclD_reg  <= 1'b1;
         sdaD_reg  <= 1'b1;
      end else begin
         syncA_reg <= {scl, sdaIn, addrPin, enablePin, ocDetect, outGood, rampDone, trackFault, 1'b0};
         syncB_reg <= syncA_reg;
         sclD_reg  <= syncB_reg[15];
         sdaD_reg  <= syncB_reg[14];
      end
   end
   wire logic       sclS   = syncB_reg[15];
   wire logic       sdaS   = syncB_reg[14];
   wire logic [1:0] addrS  = syncB_reg[13:12];
   wire logic       enPinS = syncB_reg[11];
   wire logic [3:0] ocS    = syncB_reg[10:7];
   wire logic [3:0] goodS  = syncB_reg[6:3];
   wire logic       doneS  = syncB_reg[2];
   wire logic       tfS    = syncB_reg[1];
   // Bus condition detection
   wire logic sclRise = sclS & ~sclD_reg;
   wire logic sclFall = ~sclS & sclD_reg;
   wire logic busStart = sclS & sclD_reg & sdaD_reg & ~sdaS;
   wire logic busStop  = sclS & sclD_reg & ~sdaD_reg & sdaS;
   // Register storage
   logic [7:0] cfg [NUM_REGS];
   logic [7:0] nv  [NUM_REGS];
   // Serial slave state
   stc_i2c_t   st_reg;
   logic [3:0] bitCnt_reg;
   logic [7:0] shift_reg;
   logic       ackPhase_reg;
   logic       countNext_reg;
   logic [4:0] ptr_reg;
   logic       ptrNv_reg;
   logic       sdaOe_reg;
   logic       wrEn_reg;
   logic       wrNv_reg;
   logic [4:0] wrIdx_reg;
   logic [7:0] wrData_reg;
   logic       reboot_reg;
   // Command byte decode
   wire logic [7:0] cmdByte  = shift_reg;
   wire logic       cmdCfg   = cmdByte <= POWERDOWN_PULLDOWN_CONFIG;
   wire logic       cmdNv    = (cmdByte >= CMD_NV_BASE) && (cmdByte <= CMD_NV_LAST);
   wire logic       cmdOther = (cmdByte == CMD_BLOCK_WRITE) || (cmdByte == CMD_BLOCK_WR_PREP)
                               || (cmdByte == CMD_BLOCK_RD_PREP) || (cmdByte == CMD_REBOOT);
   wire logic       addrHit  = (shift_reg[7:4] == DEV_ADDR_HI) && (shift_reg[3:2] == addrS);
   wire logic [7:0] rdByte   = ptrNv_reg ? nv[ptr_reg] : cfg[ptr_reg];
   wire logic [7:0] nvOff    = 8'(cmdByte - CMD_NV_BASE);
   // Serial slave: sample on rising clock, drive on falling clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg        <= I_IDLE;
         bitCnt_reg    <= 4'h0;
         shift_reg     <= 8'h00;
         ackPhase_reg  <= 1'b0;
         countNext_reg <= 1'b0;
         ptr_reg       <= 5'h00;
         ptrNv_reg     <= 1'b0;
         sdaOe_reg     <= 1'b0;
         wrEn_reg      <= 1'b0;
         wrNv_reg      <= 1'b0;
         wrIdx_reg     <= 5'h00;
         wrData_reg    <= 8'h00;
         reboot_reg    <= 1'b0;
      end else begin
         wrEn_reg   <= 1'b0;
         reboot_reg <= 1'b0;
         if (busStart) begin
            st_reg       <= I_ADDR;
            bitCnt_reg   <= 4'h0;
            ackPhase_reg <= 1'b0;
            sdaOe_reg    <= 1'b0;
         end else if (busStop) begin
            st_reg       <= I_IDLE;
            ackPhase_reg <= 1'b0;
            sdaOe_reg    <= 1'b0;
         end else if (sclRise && !ackPhase_reg) begin
            if (st_reg == I_RACK) begin
               if (sdaS) begin
                  st_reg <= I_IDLE;
               end else begin
                  ptr_reg      <= satInc(ptr_reg);
                  st_reg       <= I_RDATA;
                  bitCnt_reg   <= 4'h0;
                  ackPhase_reg <= 1'b1;
               end
            end else if (st_reg == I_RDATA && bitCnt_reg < 4'h8) begin
               shift_reg  <= {shift_reg[6:0], 1'b0};
               bitCnt_reg <= 4'(bitCnt_reg + 4'h1);
            end else if (st_reg != I_IDLE && bitCnt_reg < 4'h8) begin
               shift_reg  <= {shift_reg[6:0], sdaS};
               bitCnt_reg <= 4'(bitCnt_reg + 4'h1);
            end
         end else if (sclFall) begin
            if (ackPhase_reg) begin
               ackPhase_reg <= 1'b0;
               bitCnt_reg   <= 4'h0;
               sdaOe_reg    <= (st_reg == I_RDATA) ? ~rdByte[7] : 1'b0;
               if (st_reg == I_RDATA) begin
                  shift_reg <= rdByte;
               end
            end else if (st_reg == I_RDATA) begin
               if (bitCnt_reg == 4'h8) begin
                  sdaOe_reg <= 1'b0;
                  st_reg    <= I_RACK;
               end else begin
                  sdaOe_reg <= ~shift_reg[7];
               end
            end else if (bitCnt_reg == 4'h8) begin
               unique case (st_reg)
                  I_ADDR: begin
                     sdaOe_reg    <= addrHit;
                     ackPhase_reg <= addrHit;
                     st_reg       <= !addrHit ? I_IDLE : (shift_reg[0] ? I_RDATA : I_CMD);
                  end
                  I_CMD: begin
                     sdaOe_reg     <= cmdCfg | cmdNv | cmdOther;
                     ackPhase_reg  <= cmdCfg | cmdNv | cmdOther;
                     st_reg        <= (cmdCfg | cmdNv | cmdOther) ? I_WDATA : I_IDLE;
                     countNext_reg <= cmdByte == CMD_BLOCK_WRITE;
                     reboot_reg    <= cmdByte == CMD_REBOOT;
                     if (cmdCfg || cmdNv) begin
                        ptr_reg   <= cmdCfg ? cmdByte[4:0] : nvOff[4:0];
                        ptrNv_reg <= cmdNv;
                     end
                  end
                  I_WDATA: begin
                     sdaOe_reg    <= 1'b1;
                     ackPhase_reg <= 1'b1;
                     if (countNext_reg) begin
                        countNext_reg <= 1'b0;
                     end else begin
                        wrEn_reg   <= 1'b1;
                        wrNv_reg   <= ptrNv_reg;
                        wrIdx_reg  <= ptr_reg;
                        wrData_reg <= shift_reg;
                        ptr_reg    <= satInc(ptr_reg);
                     end
                  end
                  default: begin
                     st_reg <= I_IDLE;
                  end
               endcase
            end
         end
      end
   end
   // Register array: host writes, reboot reload from nonvolatile copy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            cfg[i] <= CFG_RESET;
            nv[i]  <= CFG_RESET;
         end
      end else if (reboot_reg) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            cfg[i] <= nv[i];
         end
      end else if (wrEn_reg) begin
         if (wrNv_reg) begin
            nv[wrIdx_reg] <= wrData_reg;
         end else begin
            cfg[wrIdx_reg] <= wrData_reg;
         end
      end
   end
   // Field selection
   wire logic [7:0] roleReg = cfg[DEVICE_ROLE_FAULT_ENABLE[4:0]];
   wire logic [7:0] ocmReg  = cfg[OVERCURRENT_MASK_FILTER[4:0]];
   wire logic [7:0] rmtReg  = cfg[RESET_MASK_TIMEOUT[4:0]];
   wire logic [7:0] pdnReg  = cfg[POWERDOWN_PULLDOWN_CONFIG[4:0]];
   wire logic [1:0] roleF   = roleReg[ROLE_HI:ROLE_LO];
   wire logic       standAlone = roleF == 2'b00;
   wire logic [15:0] modeRaw = {cfg[TRACK_SEQ_MODE_A[4:0]], cfg[TRACK_SEQ_MODE_B[4:0]]};
   wire logic [15:0] modeEff = standAlone ? modeRaw : {4{MODE_TRACK}};
   wire logic       hostPerm = roleReg[HOST_PERM_BIT];
   wire logic       powerReq = hostPerm ? roleReg[HOST_EN_BIT] : enPinS;
   wire logic       ocActive = |(ocS & chanOrder(ocmReg[OC_MASK_HI:OC_MASK_LO])) & powerOn;
   wire logic [1:0] ocF      = ocmReg[OC_FILT_HI:OC_FILT_LO];
   wire logic [31:0] ocLimit = cycOf((ocF == 2'h0) ? 32'd1 : 32'd4 << (ocF - 2'h1), OC_BASE_CYC);
   wire logic [2:0] rtoF     = rmtReg[RST_TO_HI:RST_TO_LO];
   wire logic [31:0] rstLimit = (rtoF == 3'h0) ? 32'(RST_MIN_CYC) :
                               (rtoF == 3'h7) ? cycOf(32'd128, RST_STEP_CYC) :
                               cycOf(32'd1 << (rtoF - 3'h1), RST_STEP_CYC);
   wire logic       rstBad   = |(~goodS & chanOrder(rmtReg[RST_MASK_HI:RST_MASK_LO]));
   wire logic [3:0] ftoF     = cfg[FAULT_TIMEOUT_CONFIG[4:0]][FTO_HI:FTO_LO];
   wire logic [31:0] fltLimit = cycOf(32'(ftoF) + 32'd1, FAULT_STEP_CYC);
   wire logic       fastBit  = pdnReg[PDN_FAST_BIT];
   // Supervisory timers and power control
   logic [31:0] ocCnt_reg;
   logic [31:0] rstCnt_reg;
   logic [31:0] fltCnt_reg;
   logic [31:0] retryCnt_reg;
   logic        faulted_reg;
   logic        ocAlert_reg;
   logic        rstN_reg;
   logic        powerOn_reg;
   wire logic   timeoutHit = powerOn_reg && !doneS && (fltCnt_reg >= fltLimit);
   wire logic   faultSet   = timeoutHit || (powerOn_reg && tfS);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ocCnt_reg    <= 32'h0;
         rstCnt_reg   <= 32'h0;
         fltCnt_reg   <= 32'h0;
         retryCnt_reg <= 32'h0;
         faulted_reg  <= 1'b0;
         ocAlert_reg  <= 1'b0;
         rstN_reg     <= 1'b0;
         powerOn_reg  <= 1'b0;
      end else begin
         ocCnt_reg   <= !ocActive ? 32'h0 : (ocCnt_reg > ocLimit ? ocCnt_reg : 32'(ocCnt_reg + 1));
         ocAlert_reg <= ocActive && (ocCnt_reg > ocLimit);
         rstCnt_reg  <= rstBad ? 32'h0 : (rstCnt_reg >= rstLimit ? rstCnt_reg : 32'(rstCnt_reg + 1));
         rstN_reg    <= !rstBad && (rstCnt_reg >= rstLimit);
         fltCnt_reg  <= (powerOn_reg && !doneS) ? 32'(fltCnt_reg + 1) : 32'h0;
         retryCnt_reg <= (faulted_reg && roleReg[RETRY_BIT]) ? 32'(retryCnt_reg + 1) : 32'h0;
         if (faultSet) begin
            faulted_reg <= 1'b1;
         end else if ((roleReg[RETRY_BIT] && retryCnt_reg >= RETRY_CYC) || !powerReq) begin
            faulted_reg <= 1'b0;
         end
         powerOn_reg <= powerReq && !faulted_reg && !faultSet;
      end
   end
   // Registered outputs
   logic       fast_reg;
   logic [3:0] pull_reg;
   logic [1:0] slew_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fast_reg <= 1'b0;
         pull_reg <= 4'h0;
         slew_reg <= 2'h0;
      end else begin
         fast_reg <= fastBit && !powerOn_reg;
         pull_reg <= pdnReg[PULL_HI:PULL_LO] & {4{(fastBit && !powerOn_reg) || tfS || faulted_reg}};
         slew_reg <= (tfS || faulted_reg) ? SLEW_FAULT : cfg[SLEW_RATE_CONFIG[4:0]][SLEW_HI:SLEW_LO];
      end
   end
   // Configuration fields presented to the analog side
   logic [15:0] mode_reg;
   logic [1:0]  role_reg;
   logic [2:0]  dly_reg;
   logic [3:0]  range_reg;
   logic [31:0] uv_reg;
   logic [31:0] ov_reg;
   logic [7:0]  oct_reg;
   logic [7:0]  pgt_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_reg  <= 16'h0;
         role_reg  <= 2'h0;
         dly_reg   <= 3'h0;
         range_reg <= 4'h0;
         uv_reg    <= 32'h0;
         ov_reg    <= 32'h0;
         oct_reg   <= 8'h00;
         pgt_reg   <= 8'h00;
      end else begin
         mode_reg  <= modeEff;
         role_reg  <= roleF;
         dly_reg   <= cfg[POWERUP_DELAY_CONFIG[4:0]][DLY_HI:DLY_LO];
         range_reg <= cfg[THRESHOLD_RANGE_SELECT[4:0]][3:0];
         uv_reg    <= {cfg[3], cfg[2], cfg[1], cfg[UV_THRESHOLD_CH1[4:0]]};
         ov_reg    <= {cfg[7], cfg[6], cfg[5], cfg[OV_THRESHOLD_CH1[4:0]]};
         oct_reg   <= cfg[OVERCURRENT_THRESHOLD[4:0]];
         pgt_reg   <= cfg[POWER_GOOD_THRESHOLD[4:0]];
      end
   end

   assign sdaOut              = 1'b0;
   assign sdaOe               = sdaOe_reg;
   assign overcurrentAlertOut = ocAlert_reg;
   assign faultAlert          = faulted_reg;
   assign resetOutN           = rstN_reg;
   assign powerOn             = powerOn_reg;
   assign fastShutdown        = fast_reg;
   assign pulldownEn          = pull_reg;
   assign slewSel             = slew_reg;
   assign seqDelaySel         = dly_reg;
   assign outMode             = mode_reg;
   assign deviceRole          = role_reg;
   assign rangeSel            = range_reg;
   assign uvThreshold         = uv_reg;
   assign ovThreshold         = ov_reg;
   assign ocThreshold         = oct_reg;
   assign pgThreshold         = pgt_reg;
   // Checks
   a_oc_mask_gate: assert property (@(posedge core_clk) disable iff (rst)
      !ocActive |=> !overcurrentAlertOut) else $error("alert without masked overcurrent");
   a_oc_filter_time: assert property (@(posedge core_clk) disable iff (rst)
      $rose(overcurrentAlertOut) |-> $past(ocActive) && ocCnt_reg > ocLimit)
      else $error("alert before filter period");
   a_fault_powerdown: assert property (@(posedge core_clk) disable iff (rst)
      faultSet |=> faultAlert ##1 !powerOn) else $error("fault did not power down");
   a_fault_latch_off: assert property (@(posedge core_clk) disable iff (rst)
      faulted_reg && !roleReg[RETRY_BIT] && powerReq && !$past(roleReg[RETRY_BIT]) |=> faulted_reg)
      else $error("latched fault cleared");
   a_rst_mask_assert: assert property (@(posedge core_clk) disable iff (rst)
      rstBad |=> !resetOutN) else $error("reset not asserted");
   a_rst_timeout_len: assert property (@(posedge core_clk) disable iff (rst)
      $rose(resetOutN) |-> $past(rstCnt_reg) >= $past(rstLimit)) else $error("reset released early");
   a_host_en_ignore: assert property (@(posedge core_clk) disable iff (rst)
      !powerReq |=> !powerOn) else $error("power on without enable");
   a_role_track_only: assert property (@(posedge core_clk) disable iff (rst)
      deviceRole != 2'b00 |-> outMode == {4{MODE_TRACK}}) else $error("sequencing in multi role");
   a_slew_fault_ovr: assert property (@(posedge core_clk) disable iff (rst)
      faulted_reg |=> slewSel == SLEW_FAULT) else $error("slew not overridden");
   a_reboot_reload: assert property (@(posedge core_clk) disable iff (rst)
      reboot_reg |=> cfg[0] == $past(nv[0])) else $error("reboot did not reload");
   c_reg_write: cover property (@(posedge core_clk) disable iff (rst) wrEn_reg && !wrNv_reg);
   c_read_byte: cover property (@(posedge core_clk) disable iff (rst) st_reg == I_RACK);
   c_fault_retry: cover property (@(posedge core_clk) disable iff (rst) $fell(faulted_reg));
   c_oc_alert: cover property (@(posedge core_clk) disable iff (rst) $rose(overcurrentAlertOut));
endmodule : stc_config_regs
`default_nettype wire

// file: stc_host_model.sv
// Two-wire bus host model that writes and reads the tracker registers.
`timescale 1ns/1ps
`default_nettype none
module stc_host_model (
   input  wire logic clk,
   output logic      scl,
   output logic      sdaLow,
   input  wire logic sdaLine
);
   import stc_pkg::*;
   logic [7:0] rdData;
   logic       ackSeen;
   // Bus idles with both lines released
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge clk);
   endtask : half
   // Data set while SCL is low, sampled at the end of the high phase
   task automatic bitx(input logic b, output logic s);
      sdaLow <= ~b;
      half();
      scl <= 1'b1;
      half();
      s = sdaLine;
      scl <= 1'b0;
      half();
   endtask : bitx
   task automatic start();
      half();
      sdaLow <= 1'b1;
      half();
      scl <= 1'b0;
      half();
   endtask : start
   task automatic stop();
      sdaLow <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sdaLow <= 1'b0;
      half();
   endtask : stop
   task automatic send(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(d[i], s);
      bitx(1'b1, ackSeen);
   endtask : send
   task automatic cmd(input logic [7:0] c);
      start();
      send({DEV_ADDR_HI, 4'h0});
      send(c);
      stop();
   endtask : cmd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      send({DEV_ADDR_HI, 4'h0});
      send(a);
      send(d);
      stop();
   endtask : wr
   // Pointer set first, then one byte read and ended by a NACK
   task automatic rd(input logic [7:0] a);
      logic s;
      cmd(a);
      start();
      send({DEV_ADDR_HI, 4'h1});
      for (int i = 7; i >= 0; i--) bitx(1'b1, rdData[i]);
      bitx(1'b1, s);
      stop();
   endtask : rd
endmodule : stc_host_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the supply tracker configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import stc_pkg::*;
   logic        core_clk = 1'b0, rst = 1'b1, enablePin = 1'b0, rampDone = 1'b1;
   logic        scl, sdaLow, sdaOe, ocAlert, faultAlert, resetOutN, powerOn, fastShutdown;
   logic [1:0]  slewSel, deviceRole;
   logic [2:0]  seqDelaySel;
   logic [3:0]  ocDetect = 4'h0, pulldownEn, rangeSel;
   logic [3:0]  outGood = 4'hf;
   logic        trackFault = 1'b0;
   logic [7:0]  ocTh, pgTh;
   logic [15:0] outMode;
   logic [31:0] uvTh, ovTh;
   wire         sdaLine = ~(sdaLow | sdaOe);
   int          n_fail = 0, cmp_count = 0;
   logic [15:0] rows [11] = '{16'h005a, 16'h04a5, 16'h073c, 16'h089a, 16'h0b12, 16'h0c34,
                              16'h0de4, 16'h0fa0, 16'h101b, 16'h1280, 16'h13c8};
   stc_host_model host (.clk(core_clk), .scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));
   stc_config_regs #(.OC_BASE_CYC(20), .RST_STEP_CYC(20), .FAULT_STEP_CYC(50), .RETRY_CYC(30))
   dut_u (.core_clk(core_clk), .rst(rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
      .addrPin(2'b00), .enablePin(enablePin), .ocDetect(ocDetect), .outGood(outGood),
      .rampDone(rampDone), .trackFault(trackFault), .overcurrentAlertOut(ocAlert),
      .faultAlert(faultAlert), .resetOutN(resetOutN), .powerOn(powerOn),
      .fastShutdown(fastShutdown), .pulldownEn(pulldownEn), .slewSel(slewSel),
      .seqDelaySel(seqDelaySel), .outMode(outMode), .deviceRole(deviceRole),
      .rangeSel(rangeSel), .uvThreshold(uvTh), .ovThreshold(ovTh), .ocThreshold(ocTh),
      .pgThreshold(pgTh));
   always #5 core_clk = ~core_clk;
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // Watchdog against a hung bus
   initial begin
      wt(90000);
      n_fail++;
      final_report();
   end
   // Main sequence: reset and default checks, table rows, then hand-written cases
   initial begin
      wt(3);
      check(resetOutN, 1'b0, "reset out");
      rst <= 1'b0;
      host.rd(8'h13);
      check(host.rdData, 8'h00, "default");
      foreach (rows[i]) host.wr(rows[i][15:8], rows[i][7:0]);
      foreach (rows[i]) begin
         host.rd(rows[i][15:8]);
         check(host.rdData, rows[i][7:0], "readback");
      end
      check(uvTh, 32'h0000005a, "uv");
      check(ovTh, 32'h3c0000a5, "ov");
      check(rangeSel, 4'ha, "range");
      check(outMode, 16'h1234, "mode");
      check(slewSel, 2'h2, "slew");
      check(seqDelaySel, 3'h5, "delay");
      check(fastShutdown, 1'b1, "fast");
      check(pulldownEn, 4'h9, "pull");
      check(ocTh, 8'he4, "oc thr");
      check(pgTh, 8'h1b, "pg thr");
      check(resetOutN, 1'b1, "reset release");
      host.wr(8'h11, 8'h12);
      outGood <= 4'he;
      wt(5);
      check(resetOutN, 1'b1, "unmasked bad");
      outGood <= 4'h7;
      wt(5);
      check(resetOutN, 1'b0, "masked bad");
      outGood <= 4'hf;
      wt(10);
      check(resetOutN, 1'b0, "reset hold");
      wt(20);
      check(resetOutN, 1'b1, "reset timeout");
      $display("test table done");
      enablePin <= 1'b1;
      wt(5);
      check(powerOn, 1'b1, "pin on");
      host.wr(8'h09, 8'h02);
      check(powerOn, 1'b0, "pin ignored");
      for (int r = 0; r < 4; r++) begin
         host.wr(8'h09, {r[1:0], 6'h03});
         check(deviceRole, r[1:0], "role");
         check(outMode, (r == 0) ? 16'h1234 : 16'h0000, "mode force");
      end
      check(powerOn, 1'b1, "host on");
      check(fastShutdown, 1'b0, "no fast");
      $display("test role done");
      host.wr(8'h0e, 8'h04);
      ocDetect <= 4'h1;
      wt(60);
      check(ocAlert, 1'b0, "oc masked");
      ocDetect <= 4'h8;
      wt(15);
      check(ocAlert, 1'b0, "oc filter");
      wt(40);
      check(ocAlert, 1'b1, "oc alert");
      ocDetect <= 4'h0;
      host.wr(8'h0a, 8'h00);
      rampDone <= 1'b0;
      wt(30);
      check(faultAlert, 1'b0, "early fault");
      wt(40);
      check(faultAlert, 1'b1, "fault");
      check(powerOn, 1'b0, "fault off");
      check(slewSel, SLEW_FAULT, "fault slew");
      check(pulldownEn, 4'h9, "fault pull");
      wt(60);
      check(faultAlert, 1'b1, "latched");
      rampDone <= 1'b1;
      host.wr(8'h09, 8'he3);
      wt(20);
      check(faultAlert, 1'b0, "retry");
      check(powerOn, 1'b1, "retry on");
      enablePin <= 1'b0;
      host.wr(8'h32, 8'h40);
      host.cmd(CMD_REBOOT);
      wt(10);
      check(slewSel, 2'h1, "reboot slew");
      check(deviceRole, 2'h0, "reboot role");
      trackFault <= 1'b1;
      wt(5);
      check(slewSel, SLEW_FAULT, "track slew");
      trackFault <= 1'b0;
      wt(5);
      check(slewSel, 2'h1, "slew back");
      $display("test fault and reboot done");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
